/* File: dadm_pkg.sv */
// constants, types and register map of the dual converter output demux
// assumes a 40 MHz system clock and a sampled input sample clock
//
// Contract
// - demux on: undelayed buses carry the later sample of each pair.
// - demux on: delayed buses carry the earlier sample, one input clock back.
// - demux off: delayed buses disabled and driven to zero.
// - out-of-range flag high when input exceeds the programmed full-scale window.
// - mirror mode: secondary pin copies the forwarded data clock exactly.
// - both data buses change in step with the forwarded data clock, except when demux off clears the delayed bus at once.
// - demux on: data clock at 1/2 input rate SDR, 1/4 DDR.
// - demux off: data clock DDR only, at half the input rate.
// - data clock stops during the termination trim of calibration.
// - trim-disable bit skips every trim after the power-on one.
// - calibration indicator high for the whole calibration cycle.
// - extended-control pin low enables registers, high means pins only.
`default_nettype none
package dadm_pkg;
	localparam int CLK_NS  = 25;
	localparam int TRIM_NS = 1000;
	localparam int CAL_NS  = 4000;
	localparam logic [15:0] TRIM_CYC = 16'((TRIM_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CAL_CYC  = 16'((CAL_NS + CLK_NS - 1) / CLK_NS);
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_STS   = 6'h00;
	localparam logic [5:0] IDX_MASK  = 6'h01;
	localparam logic [5:0] IDX_FSADJ = 6'h02;
	localparam logic [5:0] IDX_EXT   = 6'h09;
	localparam int EXT_DEMUX   = 0;
	localparam int EXT_DDR     = 1;
	localparam int EXT_MIRROR  = 2;
	localparam int EXT_TRIMDIS = 3;
	localparam int EXT_CAL     = 4;
	localparam logic [15:0] EXT_RST = 16'h0000;
	localparam int STS_OOR   = 0;
	localparam int STS_CDONE = 1;
	localparam int STS_LIVE  = 8;
	localparam logic [1:0] MASK_RST  = 2'h0;
	localparam logic [8:0] FS_RST    = 9'h080;
	localparam logic [8:0] FS_PIN_HI = 9'h080;
	localparam logic [8:0] FS_PIN_LO = 9'h060;
	// synchronised pin vector positions
	localparam int PIN_ECE_N  = 0;
	localparam int PIN_FSR    = 1;
	localparam int PIN_DEMUX  = 2;
	localparam int PIN_DDR    = 3;
	localparam int PIN_MIRROR = 4;
	localparam int PIN_CAL    = 5;
	localparam logic [5:0] PIN_RST = 6'h01;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [7:0] i;
		logic [7:0] q;
	} dadm_word_s;
	typedef struct packed {
		logic demux;
		logic ddr;
		logic mirror;
		logic trim_dis;
	} dadm_cfg_s;
	typedef enum logic [1:0] {CAL_IDLE, CAL_TRIM, CAL_MAIN} dadm_cal_e;
endpackage : dadm_pkg
`default_nettype wire

/* File: dadm_top.sv */
// output demux, forwarded clock, calibration sequencer and axi-lite regs
// assumes sample clock, analog codes and pins are asynchronous to i_clk
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dadm_top (
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_sample_clk,
	input  wire logic [9:0]           i_ain_i,
	input  wire logic [9:0]           i_ain_q,
	input  wire logic                 i_extended_control_enable_pin_n,
	input  wire logic                 i_full_scale_select_pin,
	input  wire logic                 i_demux_pin,
	input  wire logic                 i_ddr_pin,
	input  wire logic                 i_mirror_pin,
	input  wire logic                 i_cal_pin,
	output var  dadm_pkg::dadm_word_s o_bus_undelayed,
	output var  dadm_pkg::dadm_word_s o_bus_delayed,
	output var  logic                 o_bus_delayed_oe,
	output var  logic                 o_fwd_data_clock,
	output var  logic                 o_out_of_range_mirror,
	output var  logic                 o_calibration_active,
	output var  logic                 o_irq,
	input  wire logic                 i_axi_awvalid,
	output var  logic                 o_axi_awready,
	input  wire logic [7:0]           i_axi_awaddr,
	input  wire logic                 i_axi_wvalid,
	output var  logic                 o_axi_wready,
	input  wire logic [31:0]          i_axi_wdata,
	input  wire logic [3:0]           i_axi_wstrb,
	output var  logic                 o_axi_bvalid,
	input  wire logic                 i_axi_bready,
	output var  logic [1:0]           o_axi_bresp,
	input  wire logic                 i_axi_arvalid,
	output var  logic                 o_axi_arready,
	input  wire logic [7:0]           i_axi_araddr,
	output var  logic                 o_axi_rvalid,
	input  wire logic                 i_axi_rready,
	output var  logic [31:0]          o_axi_rdata,
	output var  logic [1:0]           o_axi_rresp
);
	import dadm_pkg::*;

	// signed input clipped to an offset-binary 8-bit code
	function automatic logic [7:0] clamp(input logic [9:0] x);
		if ($signed(x) > 10'sd127)
			return 8'hff;
		else if ($signed(x) < -10'sd128)
			return 8'h00;
		else
			return x[7:0] ^ 8'h80;
	endfunction : clamp

	// magnitude beyond the full-scale window
	function automatic logic outside(input logic [9:0] x,
	                                 input logic [8:0] lim);
		logic signed [10:0] v;
		v = 11'($signed(x));
		return (v > $signed({2'b00, lim})) || (v < -$signed({2'b00, lim}));
	endfunction : outside

	// byte-lane merge for register writes
	function automatic logic [31:0] wmerge(input logic [31:0] o,
	                                       input logic [31:0] d,
	                                       input logic [3:0]  s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = d[b*8 +: 8];
		return r;
	endfunction : wmerge

	logic [5:0]  pins_s1, pins_s2;
	logic [9:0]  ai_s1, ai_s2, aq_s1, aq_s2;
	logic        sclk_s1, sclk_s2, sclk_s3;
	logic        cal_prev_q;
	logic [15:0] ext_q;
	logic [8:0]  fs_q;
	logic [1:0]  mask_q, sts_q;
	dadm_cfg_s   cfg;
	logic        pin_mode;
	logic [8:0]  lim;
	dadm_cal_e   st_q;
	logic [15:0] ccnt_q;
	logic        por_q, first_done_q, sw_cal_q, cal_req, cal_done;
	logic        edge_s, run, phase_q, clk_d, upd, oor_now, oor_q, oor_d;
	dadm_word_s  cur, hold_q;
	logic        aw_q, w_q, wr_go, rd_go;
	logic [5:0]  awi_q, ari;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;

	// two-flop synchronisers; the second stage feeds logic, the sample clock also via a third flop for edge detection
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pins_s1 <= PIN_RST;
			pins_s2 <= PIN_RST;
			ai_s1   <= 10'h000;
			ai_s2   <= 10'h000;
			aq_s1   <= 10'h000;
			aq_s2   <= 10'h000;
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
		end else begin
			pins_s1 <= {i_cal_pin, i_mirror_pin, i_ddr_pin, i_demux_pin,
			            i_full_scale_select_pin,
			            i_extended_control_enable_pin_n};
			pins_s2 <= pins_s1;
			ai_s1   <= i_ain_i;
			ai_s2   <= ai_s1;
			aq_s1   <= i_ain_q;
			aq_s2   <= aq_s1;
			sclk_s1 <= i_sample_clk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
		end
	end

	// pin control or register control selects the live configuration
	assign pin_mode = pins_s2[PIN_ECE_N];
	always_comb begin
		if (pin_mode) begin
			cfg = '{demux: pins_s2[PIN_DEMUX], ddr: pins_s2[PIN_DDR],
			        mirror: pins_s2[PIN_MIRROR], trim_dis: 1'b0};
			lim = pins_s2[PIN_FSR] ? FS_PIN_HI : FS_PIN_LO;
		end else begin
			cfg = '{demux: ext_q[EXT_DEMUX], ddr: ext_q[EXT_DDR],
			        mirror: ext_q[EXT_MIRROR],
			        trim_dis: ext_q[EXT_TRIMDIS]};
			lim = fs_q;
		end
	end

	// calibration requests: power-on, pin rising edge, software strobe
	assign cal_req  = por_q | sw_cal_q | (pins_s2[PIN_CAL] & ~cal_prev_q);
	assign cal_done = (st_q == CAL_MAIN) && (ccnt_q == CAL_CYC - 16'd1);

	// calibration sequencer; requests during a cycle are dropped
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q         <= CAL_IDLE;
			ccnt_q       <= 16'h0000;
			por_q        <= 1'b1;
			first_done_q <= 1'b0;
			cal_prev_q   <= 1'b0;
		end else begin
			cal_prev_q <= pins_s2[PIN_CAL];
			case (st_q)
				CAL_IDLE: begin
					ccnt_q <= 16'h0000;
					if (cal_req) begin
						por_q <= 1'b0;
						if (!first_done_q || !cfg.trim_dis)
							st_q <= CAL_TRIM;
						else
							st_q <= CAL_MAIN;
					end
				end
				CAL_TRIM: begin
					ccnt_q <= ccnt_q + 16'd1;
					if (ccnt_q == TRIM_CYC - 16'd1) begin
						st_q         <= CAL_MAIN;
						ccnt_q       <= 16'h0000;
						first_done_q <= 1'b1;
					end
				end
				CAL_MAIN: begin
					ccnt_q <= ccnt_q + 16'd1;
					if (cal_done)
						st_q <= CAL_IDLE;
				end
				default: st_q <= CAL_IDLE;
			endcase
		end
	end

	// indicator decoded straight from the state flop
	assign o_calibration_active = (st_q != CAL_IDLE);

	// sample edge; trim freezes the forwarded clock and data
	assign edge_s  = sclk_s2 & ~sclk_s3;
	assign run     = edge_s && (st_q != CAL_TRIM);
	assign cur     = '{i: clamp(ai_s2), q: clamp(aq_s2)};
	assign oor_now = outside(ai_s2, lim) | outside(aq_s2, lim);
	assign oor_d   = edge_s ? oor_now : oor_q;

	// clock divider: data move only where the forwarded clock switches
	always_comb begin
		clk_d = o_fwd_data_clock;
		upd   = 1'b0;
		if (run) begin
			if (!cfg.demux) begin
				clk_d = ~o_fwd_data_clock; // ddr only, half rate
				upd   = 1'b1;
			end else if (cfg.ddr) begin
				clk_d = phase_q ? ~o_fwd_data_clock : o_fwd_data_clock;
				upd   = phase_q;
			end else begin
				clk_d = phase_q; // sdr, rises with each pair
				upd   = phase_q;
			end
		end
	end

	// demux phase and hold register for the earlier sample
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_q <= 1'b0;
			hold_q  <= '0;
		end else begin
			if (!cfg.demux)
				phase_q <= 1'b0;
			else if (run)
				phase_q <= ~phase_q;
			if (run && !phase_q)
				hold_q <= cur;
		end
	end

	// output flops; delayed bus zeroed and disabled outside demux
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_bus_undelayed       <= '0;
			o_bus_delayed         <= '0;
			o_bus_delayed_oe      <= 1'b0;
			o_fwd_data_clock      <= 1'b0;
			o_out_of_range_mirror <= 1'b0;
			oor_q                 <= 1'b0;
		end else begin
			if (upd)
				o_bus_undelayed <= cur;
			// cleared at once, not at the next update, so no stale word stays
			if (!cfg.demux)
				o_bus_delayed <= '0;
			else if (upd)
				o_bus_delayed <= hold_q;
			o_bus_delayed_oe <= cfg.demux;
			o_fwd_data_clock <= clk_d;
			oor_q            <= oor_d;
			o_out_of_range_mirror <= cfg.mirror ? clk_d : oor_d;
		end
	end

	// axi-lite write: address and data latched in either order
	assign o_axi_awready = !aw_q;
	assign o_axi_wready  = !w_q;
	assign wr_go         = aw_q && w_q && !o_axi_bvalid;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awi_q        <= 6'h00;
			wd_q         <= 32'h0000_0000;
			ws_q         <= 4'h0;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp  <= RESP_OKAY;
		end else begin
			if (wr_go)
				aw_q <= 1'b0;
			else if (i_axi_awvalid && o_axi_awready) begin
				aw_q  <= 1'b1;
				awi_q <= i_axi_awaddr[7:2];
			end
			if (wr_go)
				w_q <= 1'b0;
			else if (i_axi_wvalid && o_axi_wready) begin
				w_q  <= 1'b1;
				wd_q <= i_axi_wdata;
				ws_q <= i_axi_wstrb;
			end
			if (wr_go) begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= (awi_q == IDX_MASK || awi_q == IDX_FSADJ ||
				                 awi_q == IDX_EXT) ? RESP_OKAY : RESP_SLVERR;
			end else if (i_axi_bready)
				o_axi_bvalid <= 1'b0;
		end
	end

	// writable registers; extended config locked while pins rule
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mask_q   <= MASK_RST;
			fs_q     <= FS_RST;
			ext_q    <= EXT_RST;
			sw_cal_q <= 1'b0;
		end else begin
			sw_cal_q <= 1'b0;
			if (wr_go && awi_q == IDX_MASK)
				mask_q <= 2'(wmerge({30'h0, mask_q}, wd_q, ws_q));
			if (wr_go && awi_q == IDX_FSADJ)
				fs_q <= 9'(wmerge({23'h0, fs_q}, wd_q, ws_q));
			if (wr_go && awi_q == IDX_EXT && !pin_mode) begin
				ext_q <= 16'(wmerge({16'h0, ext_q}, wd_q, ws_q));
				sw_cal_q <= ws_q[0] & wd_q[EXT_CAL];
			end
		end
	end

	// axi-lite read; a status read clears sticky bits, new events win
	assign o_axi_arready = !o_axi_rvalid;
	assign rd_go         = i_axi_arvalid && o_axi_arready;
	assign ari           = i_axi_araddr[7:2];
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_axi_rvalid <= 1'b0;
			o_axi_rdata  <= 32'h0000_0000;
			o_axi_rresp  <= RESP_OKAY;
			sts_q        <= 2'h0;
		end else begin
			if (rd_go) begin
				o_axi_rvalid <= 1'b1;
				o_axi_rresp  <= RESP_OKAY;
				case (ari)
					IDX_STS:   o_axi_rdata <= 32'({pin_mode,
					                 o_calibration_active, 6'h00, sts_q});
					IDX_MASK:  o_axi_rdata <= {30'h0, mask_q};
					IDX_FSADJ: o_axi_rdata <= {23'h0, fs_q};
					IDX_EXT:   o_axi_rdata <= 32'h0000_0000;
					default: begin
						o_axi_rdata <= 32'h0000_0000;
						o_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (i_axi_rready)
				o_axi_rvalid <= 1'b0;
			sts_q <= ((rd_go && ari == IDX_STS) ? 2'h0 : sts_q) |
			         {cal_done, edge_s & oor_now};
		end
	end

	assign o_irq = |(sts_q & mask_q);

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_sdr_pair;
		run && cfg.demux && !cfg.ddr && phase_q;
	endsequence
	sequence s_first_of_pair;
		run && cfg.demux && !phase_q;
	endsequence

	property p_later;
		upd && cfg.demux |=> o_bus_undelayed == $past(cur);
	endproperty
	a_later: assert property (p_later)
		else $error("undelayed bus lost the later sample");
	property p_earlier;
		s_first_of_pair |=> hold_q == $past(cur);
	endproperty
	a_earlier: assert property (p_earlier)
		else $error("first sample of a pair was not held");
	property p_delayed;
		upd && cfg.demux |=> o_bus_delayed == $past(hold_q);
	endproperty
	a_delayed: assert property (p_delayed)
		else $error("delayed bus did not show the held sample");
	property p_off;
		!cfg.demux |=> !o_bus_delayed_oe && o_bus_delayed == '0;
	endproperty
	a_off: assert property (p_off)
		else $error("delayed bus driven with demux off");
	property p_oor;
		edge_s && oor_now && !cfg.mirror |=> o_out_of_range_mirror;
	endproperty
	a_oor: assert property (p_oor)
		else $error("out-of-range flag missed");
	property p_mirror;
		$past(cfg.mirror) |-> o_out_of_range_mirror == o_fwd_data_clock;
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("mirror clock differs from data clock");
	property p_sync;
		s_sdr_pair |=> $rose(o_fwd_data_clock) && $changed(phase_q);
	endproperty
	a_sync: assert property (p_sync)
		else $error("sdr data not aligned to rising clock");
	property p_ddr4;
		s_first_of_pair ##0 cfg.ddr |=> $stable(o_fwd_data_clock);
	endproperty
	a_ddr4: assert property (p_ddr4)
		else $error("ddr demux clock faster than quarter rate");
	property p_nodemux;
		run && !cfg.demux |=> o_fwd_data_clock != $past(o_fwd_data_clock);
	endproperty
	a_nodemux: assert property (p_nodemux)
		else $error("non-demux clock failed to toggle per sample");
	property p_trim;
		st_q == CAL_TRIM |=> $stable(o_fwd_data_clock);
	endproperty
	a_trim: assert property (p_trim)
		else $error("data clock moved during trim");
	property p_skip;
		st_q == CAL_IDLE && cal_req && first_done_q && cfg.trim_dis
			|=> st_q == CAL_MAIN;
	endproperty
	a_skip: assert property (p_skip)
		else $error("trim ran although disabled");
	property p_calibration_active;
		st_q == CAL_IDLE && cal_req |=> o_calibration_active[*8];
	endproperty
	a_calibration_active: assert property (p_calibration_active)
		else $error("calibration indicator dropped early");
	property p_lock;
		wr_go && awi_q == IDX_EXT && pin_mode |=> $stable(ext_q);
	endproperty
	a_lock: assert property (p_lock)
		else $error("extended config written in pin mode");
endmodule : dadm_top
`default_nettype wire

/* File: dadm_capture.sv */
// capture model of the receiving logic beside the output buses
// assumes the forwarded clock is a register output of the i_clk domain
`timescale 1ns/1ps
`default_nettype none
module dadm_capture (
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_fwd_data_clock,
	input  wire logic                 i_ddr,
	input  wire dadm_pkg::dadm_word_s i_undel,
	input  wire dadm_pkg::dadm_word_s i_del,
	output var  dadm_pkg::dadm_word_s o_undel,
	output var  dadm_pkg::dadm_word_s o_del,
	output var  logic [15:0]          o_count
);
	import dadm_pkg::*;
	logic fwd_data_clock_q;
	// edges are found by sampling, the data clock never clocks logic
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fwd_data_clock_q  <= 1'b0;
			o_undel <= '0;
			o_del   <= '0;
			o_count <= 16'h0000;
		end else begin
			fwd_data_clock_q <= i_fwd_data_clock;
			// rising edge only in sdr, both edges in ddr
			if (i_fwd_data_clock != fwd_data_clock_q && (i_fwd_data_clock || i_ddr)) begin
				o_undel <= i_undel;
				o_del   <= i_del;
				o_count <= o_count + 16'h0001;
			end
		end
	end
endmodule : dadm_capture
`default_nettype wire

/* File: dadm_top_bench.sv */
// self-checking bench for the output demux, with a capture model
// assumes the package, design and capture model are compiled first
`timescale 1ns/1ps
`default_nettype none
module dadm_top_bench;
	import dadm_pkg::*;
	typedef struct packed {
		logic       dm, dd, fs;
		logic [9:0] ai, aq;
		logic [7:0] ci, cq;
		logic       orr;
		logic [4:0] gap;
	} dadm_row_s;
	localparam dadm_row_s ROWS [5] = '{
		{3'b001, 10'h005, 10'h3fb, 8'h85, 8'h7b, 1'b0, 5'd8},
		{3'b101, 10'h3fb, 10'h005, 8'h7b, 8'h85, 1'b0, 5'd8},
		{3'b110, 10'h070, 10'h000, 8'hf0, 8'h80, 1'b1, 5'd16},
		{3'b011, 10'h200, 10'h010, 8'h00, 8'h90, 1'b1, 5'd8},
		{3'b101, 10'h1ff, 10'h3a0, 8'hff, 8'h20, 1'b1, 5'd8}
	};
	logic        clk = 0, rstn = 0, sclk = 0, sp = 0, ramp = 0;
	logic        ece_n = 1, full_scale_select_pin = 1, dmx = 0, ddr = 0, mir = 0, cal = 0;
	logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [9:0]  ai = '0, aq = '0, ai_ramp = '0;
	logic [1:0]  sdiv = '0;
	logic [7:0]  awa = '0, ara = '0;
	logic [31:0] wd = '0, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] ccnt;
	logic        oe, fwd_data_clock, oorm, cact, irq, awr, wr, bv, arr, rv;
	dadm_word_s  undel, del, cu, cd;
	int          failures = 0, check_count = 0, p, len, tg;

	// system clock, 25 ns period
	always #12.5 clk = ~clk;
	// sample clock of 200 ns from a divider; the ramp steps after its fall,
	// far from the rising edge at which the design takes a sample
	always @(posedge clk) begin
		sdiv <= sdiv + 2'd1;
		if (sdiv == 2'd3)
			sclk <= ~sclk;
		sp <= sclk;
		if (!ramp)
			ai_ramp <= 10'h000;
		else if (sp && !sclk)
			ai_ramp <= ai_ramp + 10'h001;
	end

	dadm_top i_dut (
		.i_clk(clk), .i_resetn(rstn), .i_sample_clk(sclk),
		.i_ain_i(ramp ? ai_ramp : ai), .i_ain_q(aq),
		.i_extended_control_enable_pin_n(ece_n),
		.i_full_scale_select_pin(full_scale_select_pin), .i_demux_pin(dmx),
		.i_ddr_pin(ddr), .i_mirror_pin(mir), .i_cal_pin(cal),
		.o_bus_undelayed(undel), .o_bus_delayed(del),
		.o_bus_delayed_oe(oe), .o_fwd_data_clock(fwd_data_clock),
		.o_out_of_range_mirror(oorm), .o_calibration_active(cact),
		.o_irq(irq), .i_axi_awvalid(awv), .o_axi_awready(awr),
		.i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wr),
		.i_axi_wdata(wd), .i_axi_wstrb(4'hf), .o_axi_bvalid(bv),
		.i_axi_bready(br), .o_axi_bresp(bresp), .i_axi_arvalid(arv),
		.o_axi_arready(arr), .i_axi_araddr(ara), .o_axi_rvalid(rv),
		.i_axi_rready(rr), .o_axi_rdata(rdata), .o_axi_rresp(rresp)
	);
	// receiver model; without demux the design always runs ddr
	dadm_capture i_cap (
		.i_clk(clk), .i_resetn(rstn), .i_fwd_data_clock(fwd_data_clock), .i_ddr(ddr | ~dmx),
		.i_undel(undel), .i_del(del), .o_undel(cu), .o_del(cd),
		.o_count(ccnt)
	);

	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// a wait that used up its bound ends the run as a mismatch
	task automatic lim(input int c, input int b);
		if (c >= b) begin
			failures++;
			finish_test();
		end
	endtask : lim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// readies are looked at on the falling edge, where they are settled
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic at, wt, bt;
		int   k;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv  <= 1'b1;
		wd  <= v;
		br  <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(negedge clk);
			at = awv && awr;
			wt = wv && wr;
			bt = bv;
			r  = bresp;
			@(posedge clk);
			if (at)
				awv <= 1'b0;
			if (wt)
				wv <= 1'b0;
			if (bt)
				break;
		end
		br <= 1'b0;
		lim(k, 200);
	endtask : axw
	task automatic axr(input logic [7:0] a);
		logic at, rt;
		int   k;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rr  <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(negedge clk);
			at = arv && arr;
			rt = rv;
			d  = rdata;
			r  = rresp;
			@(posedge clk);
			if (at)
				arv <= 1'b0;
			if (rt)
				break;
		end
		rr <= 1'b0;
		lim(k, 200);
	endtask : axr
	// cycles between two switches of the forwarded data clock
	task automatic tog_gap(output int g);
		logic o;
		int   c;
		@(negedge clk);
		o = fwd_data_clock;
		for (c = 0; c < 64 && fwd_data_clock === o; c++)
			@(negedge clk);
		lim(c, 64);
		o = fwd_data_clock;
		g = 0;
		for (c = 0; c < 64 && fwd_data_clock === o; c++) begin
			@(negedge clk);
			g++;
		end
		lim(c, 64);
	endtask : tog_gap
	// length of one calibration and clock switches inside its trim part
	task automatic calw(output int n, output int t);
		logic o;
		int   c;
		for (c = 0; c < 400 && cact !== 1'b1; c++)
			@(negedge clk);
		lim(c, 400);
		n = 0;
		t = 0;
		o = fwd_data_clock;
		for (c = 0; c < 400 && cact === 1'b1; c++) begin
			@(negedge clk);
			n++;
			if (fwd_data_clock !== o && n > 2 && n < 40)
				t++;
			o = fwd_data_clock;
		end
		lim(c, 400);
	endtask : calw
	task automatic capw;
		logic [15:0] o;
		int          c;
		o = ccnt;
		for (c = 0; c < 64 && ccnt === o; c++)
			@(negedge clk);
		lim(c, 64);
	endtask : capw

	// main sequence: reset, table, then the awkward cases
	initial begin
		repeat (16) @(posedge clk);
		chk(oe, 1'b0);
		rstn <= 1'b1;
		calw(len, tg);
		chk(len, 200);
		chk(tg, 0);
		// register defaults, a write-only place and an unmapped one
		axr({IDX_FSADJ, 2'b00});
		chk(d, 32'h80);
		chk(r, RESP_OKAY);
		axr({IDX_EXT, 2'b00});
		chk(d, 32'h0);
		axr(8'h10);
		chk(r, RESP_SLVERR);
		chk(d, 32'h0);
		axw(8'h10, 32'h1);
		chk(r, RESP_SLVERR);
		// pin mode ignores the extended register
		axw({IDX_EXT, 2'b00}, 32'h1);
		tog_gap(p);
		chk(oe, 1'b0);
		foreach (ROWS[i]) begin
			@(posedge clk);
			dmx <= ROWS[i].dm;
			ddr <= ROWS[i].dd;
			full_scale_select_pin <= ROWS[i].fs;
			ai  <= ROWS[i].ai;
			aq  <= ROWS[i].aq;
			tog_gap(p);
			tog_gap(p);
			chk(p, ROWS[i].gap);
			chk(undel, {ROWS[i].ci, ROWS[i].cq});
			chk(oe, ROWS[i].dm);
			chk(oorm, ROWS[i].orr);
			if (!ROWS[i].dm)
				chk(del, 16'h0);
		end
		// ramped samples, captured by the receiver in sdr and ddr
		@(posedge clk);
		ai   <= 10'h000;
		ramp <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			ddr <= m[0];
			dmx <= 1'b1;
			tog_gap(p);
			tog_gap(p);
			repeat (6) begin
				capw();
				chk(cu.i, cd.i + 8'h01);
			end
		end
		@(posedge clk);
		ramp <= 1'b0;
		mir  <= 1'b1;
		tog_gap(p);
		repeat (16) begin
			@(negedge clk);
			chk(oorm, fwd_data_clock);
		end
		@(posedge clk);
		mir <= 1'b0;
		// pin request: the trim stops the clock
		cal <= 1'b1;
		calw(len, tg);
		chk(len, 200);
		chk(tg, 0);
		@(posedge clk);
		cal   <= 1'b0;
		ece_n <= 1'b0;
		dmx   <= 1'b0;
		ai    <= 10'h020;
		axw({IDX_FSADJ, 2'b00}, 32'h10);
		axw({IDX_EXT, 2'b00}, 32'h3);
		tog_gap(p);
		tog_gap(p);
		chk(p, 16);
		chk(oe, 1'b1);
		chk(oorm, 1'b1);
		// trim disabled: a later calibration keeps the clock running
		@(posedge clk);
		ai <= 10'h000;
		axw({IDX_EXT, 2'b00}, 32'h0b);
		fork
			axw({IDX_EXT, 2'b00}, 32'h1b);
			calw(len, tg);
		join
		chk(len, 160);
		chk(tg > 0, 1'b1);
		// interrupt masked, unmasked, then cleared by a status read
		axw({IDX_MASK, 2'b00}, 32'h0);
		ai <= 10'h100;
		tog_gap(p);
		chk(irq, 1'b0);
		axw({IDX_MASK, 2'b00}, 32'h1);
		@(negedge clk);
		chk(irq, 1'b1);
		@(posedge clk);
		ai <= 10'h000;
		tog_gap(p);
		tog_gap(p);
		axr({IDX_STS, 2'b00});
		chk(d & 32'h303, 32'h003);
		@(negedge clk);
		chk(irq, 1'b0);
		axr({IDX_STS, 2'b00});
		chk(d[1:0], 2'b00);
		finish_test();
	end
endmodule : dadm_top_bench
`default_nettype wire
